// ==== sfc_pkg.sv ====
// Shared constants and types of the serial-flash configuration loader.
package sfc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int REPROG_MIN_NS = 300;
  localparam int REPROG_CYC    = (REPROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLEAR_CYC_DEF = 64;
  localparam int DIV_SLOW_DEF  = 8;
  localparam int DIV_FAST_DEF  = 3;

  // ---------------------------------------------------------------
  // Pin codes and flash commands
  // ---------------------------------------------------------------
  localparam logic [2:0]  MODE_SPI    = 3'h1;
  localparam logic [2:0]  VAR_FAST    = 3'h7;
  localparam logic [2:0]  VAR_READ    = 3'h5;
  localparam logic [2:0]  VAR_ARRAY   = 3'h6;
  localparam logic [7:0]  CMD_FAST    = 8'h0b;
  localparam logic [7:0]  CMD_READ    = 8'h03;
  localparam logic [7:0]  CMD_ARRAY   = 8'he8;
  localparam logic [1:0]  DUMMY_FAST  = 2'h1;
  localparam logic [1:0]  DUMMY_READ  = 2'h0;
  localparam logic [1:0]  DUMMY_ARRAY = 2'h3;
  localparam int          CMD_W       = 8;
  localparam int          ADDR_W      = 24;
  localparam int          DUMMY_MAX   = 3;
  localparam logic [23:0] START_ADDR_DEF = 24'h000000;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       reprog_n;
    logic       init;
    logic       done;
    logic       pullup_dis;
    logic [2:0] mode;
    logic [2:0] variant;
  } sfc_pins_s;

  typedef struct packed {
    logic [7:0] cmd;
    logic [1:0] dummy;
    logic       ok;
  } sfc_rd_s;

  // Maps a flash variant code to its read command and dummy byte count.
  function automatic sfc_rd_s sfc_decode(logic [2:0] v);
    sfc_rd_s r;
    r = '{cmd: CMD_READ, dummy: DUMMY_READ, ok: 1'b0};
    case (v)
      VAR_FAST:  r = '{cmd: CMD_FAST, dummy: DUMMY_FAST, ok: 1'b1};
      VAR_READ:  r = '{cmd: CMD_READ, dummy: DUMMY_READ, ok: 1'b1};
      VAR_ARRAY: r = '{cmd: CMD_ARRAY, dummy: DUMMY_ARRAY, ok: 1'b1};
      default:   r.ok = 1'b0;
    endcase
    return r;
  endfunction

endpackage

// ==== sfc_spi_reader.sv ====
// Flash read engine running on the oscillator clock.
`timescale 1ns/1ps
module sfc_spi_reader #(
  parameter int          SLOW_DIV   = sfc_pkg::DIV_SLOW_DEF,
  parameter int          FAST_DIV   = sfc_pkg::DIV_FAST_DEF,
  parameter logic [23:0] START_ADDR = sfc_pkg::START_ADDR_DEF
) (
  // Clock and reset
  input  wire logic            osc_clk_i,
  input  wire logic            arst_n_i,
  // Control from the main clock domain
  input  wire logic            go_i,
  input  wire logic            fast_i,
  input  wire sfc_pkg::sfc_rd_s rd_i,
  // Flash pins
  output logic                 cs_n_o,
  output logic                 sclk_o,
  output logic                 mosi_o,
  input  wire logic            din_i,
  // Received bytes
  output logic [7:0]           byte_o,
  output logic                 byte_tgl_o
);

  localparam int         HDR_W    = sfc_pkg::CMD_W + sfc_pkg::ADDR_W + 8 * sfc_pkg::DUMMY_MAX;
  localparam logic [5:0] HDR_BASE = 6'(sfc_pkg::CMD_W + sfc_pkg::ADDR_W);
  localparam logic [7:0] SLOW_M1  = 8'(SLOW_DIV - 1);
  localparam logic [7:0] FAST_M1  = 8'(FAST_DIV - 1);

  if (FAST_DIV < 3 || SLOW_DIV < FAST_DIV || SLOW_DIV > 256) begin : g_bad_div
    $error("sfc_spi_reader: divider values out of range");
  end

  logic rs1_r, rst_n_r, go_s1_r, go_s_r, fast_s1_r, fast_s_r, din_s1_r, din_s_r;
  logic run_r, fast_en_r, tick, rise, fall, start, hdr_done;
  logic [7:0]       dcnt_r;
  logic [HDR_W-1:0] hdr_r;
  logic [5:0]       hcnt_r, hlen;
  logic [6:0]       sh_r;
  logic [2:0]       rcnt_r;

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge osc_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rs1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rst_n_r <= rs1_r;
    end
  end

  always_ff @(posedge osc_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      {go_s1_r, go_s_r, fast_s1_r, fast_s_r, din_s1_r, din_s_r} <= 6'h00;
    end else begin
      {go_s1_r, fast_s1_r, din_s1_r} <= {go_i, fast_i, din_i};
      {go_s_r, fast_s_r, din_s_r} <= {go_s1_r, fast_s1_r, din_s1_r};
    end
  end

  // ---------------------------------------------------------------
  // Clock divider and select
  // ---------------------------------------------------------------
  assign tick     = dcnt_r >= (fast_en_r ? FAST_M1 : SLOW_M1);
  assign start    = !run_r && go_s_r;
  assign rise     = run_r && go_s_r && tick && !sclk_o;
  assign fall     = run_r && go_s_r && tick && sclk_o;
  assign hlen     = HDR_BASE + {1'b0, rd_i.dummy, 3'h0};
  assign hdr_done = hcnt_r == hlen;

  always_ff @(posedge osc_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      run_r <= 1'b0;
      cs_n_o <= 1'b1;
      sclk_o <= 1'b0;
      dcnt_r <= 8'h00;
    end else if (!run_r) begin
      run_r <= go_s_r;
      cs_n_o <= !go_s_r;
      sclk_o <= 1'b0;
      dcnt_r <= 8'h00;
    end else if (!go_s_r) begin
      run_r <= 1'b0;
      cs_n_o <= 1'b1;
      sclk_o <= 1'b0;
    end else if (tick) begin
      sclk_o <= !sclk_o;
      dcnt_r <= 8'h00;
    end else begin
      dcnt_r <= dcnt_r + 8'h01;
    end
  end

  // The rate may rise only once the read header is out.
  always_ff @(posedge osc_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fast_en_r <= 1'b0;
    end else begin
      fast_en_r <= run_r && go_s_r && hdr_done && fast_s_r;
    end
  end

  // ---------------------------------------------------------------
  // Command, address and dummy bytes out
  // ---------------------------------------------------------------
  always_ff @(posedge osc_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hdr_r <= '0;
      mosi_o <= 1'b0;
      hcnt_r <= 6'h00;
    end else if (start) begin
      hdr_r <= {rd_i.cmd, START_ADDR, {(8 * sfc_pkg::DUMMY_MAX){1'b0}}};
      mosi_o <= rd_i.cmd[7];
      hcnt_r <= 6'h00;
    end else if (fall) begin
      hdr_r <= {hdr_r[HDR_W-2:0], 1'b0};
      mosi_o <= hdr_r[HDR_W-2];
    end else if (rise && !hdr_done) begin
      hcnt_r <= hcnt_r + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // Bitstream in
  // ---------------------------------------------------------------
  always_ff @(posedge osc_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sh_r <= 7'h00;
      rcnt_r <= 3'h0;
      byte_o <= 8'h00;
      byte_tgl_o <= 1'b0;
    end else if (start) begin
      rcnt_r <= 3'h0;
    end else if (rise && hdr_done) begin
      sh_r <= {sh_r[5:0], din_s_r};
      rcnt_r <= rcnt_r + 3'h1;
      if (rcnt_r == 3'h7) begin
        byte_o <= {sh_r, din_s_r};
        byte_tgl_o <= !byte_tgl_o;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge osc_clk_i); endclocking
  default disable iff (!rst_n_r);

  a_cmd_first: assert property ($fell(cs_n_o) |-> mosi_o == rd_i.cmd[7] && !sclk_o)
    else $error("first command bit not presented at select");
  a_mosi_fall: assert property ((!cs_n_o && !$past(cs_n_o) && $changed(mosi_o)) |-> $fell(sclk_o))
    else $error("data out moved off the falling clock edge");
  a_slow_start: assert property ((!cs_n_o && !hdr_done) |-> !fast_en_r)
    else $error("fast rate used before header finished");
  a_byte_pack: assert property ($changed(byte_tgl_o) |-> $past(rcnt_r) == 3'h7 && $past(rise))
    else $error("byte delivered without eight sampled bits");

endmodule // sfc_spi_reader

// ==== sfc_config_loader.sv ====
// Serial-flash configuration loader top level.
// How it works
// - The loader neither drives nor reads flash write-protect or hold.
// - Mode and variant pins are latched as the init indicator rises.
// - After done goes high, mode and variant pins are released to users.
// - While configuring, pull-ups are on when the pull-up pin is low.
// - The chain output is actively driven throughout configuration.
// - Mode pins 0,0,1 select flash mode; anything else fails.
// - The latched variant code chooses the flash read protocol.
// - Read command then start address are shifted out on the data line.
// - The bitstream arrives serially on the flash data input pin.
// - Select, clock, data out and data in wire one-to-one to the flash.
// - Variant codes give 0x0b/1 dummy, 0x03/0, 0xe8/3; others reserved.
// - Init is held low while memory clears, then released for sampling.
// - Clock comes from the oscillator, starts slow, speeds up on request.
`timescale 1ns/1ps
module sfc_config_loader #(
  parameter int          CLEAR_CYC  = sfc_pkg::CLEAR_CYC_DEF,
  parameter int          SLOW_DIV   = sfc_pkg::DIV_SLOW_DEF,
  parameter int          FAST_DIV   = sfc_pkg::DIV_FAST_DEF,
  parameter logic [23:0] START_ADDR = sfc_pkg::START_ADDR_DEF
) (
  // Clocks and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       osc_clk_i,
  // Configuration control pins
  input  wire logic       reprogram_n_i,
  input  wire logic [2:0] mode_pins_i,
  input  wire logic [2:0] flash_variant_pins_i,
  input  wire logic       pullup_disable_pin_i,
  // Open-drain init indicator
  input  wire logic       init_i,
  output logic            init_o,
  output logic            init_oe_o,
  // Open-drain done indicator
  input  wire logic       done_i,
  output logic            done_o,
  output logic            done_oe_o,
  // Flash pins
  output logic            flash_select_n_o,
  output logic            config_clock_o,
  output logic            mosi_o,
  input  wire logic       din_i,
  // Chain output
  output logic            chain_out_o,
  output logic            chain_out_oe_o,
  // Bitstream side
  input  wire logic       load_complete_i,
  input  wire logic       fast_rate_i,
  output logic [7:0]      data_o,
  output logic            data_valid_o,
  // Status
  output logic            pullup_en_o,
  output logic            pins_released_o,
  output logic            configuring_o,
  output logic            mode_error_o
);

  localparam logic [15:0] CLEAR_M1 = 16'(CLEAR_CYC - 1);
  localparam logic [7:0]  PROG_CYC = 8'(sfc_pkg::REPROG_CYC);

  if (CLEAR_CYC < 1 || CLEAR_CYC > 65536) begin : g_bad_clear
    $error("sfc_config_loader: CLEAR_CYC out of range");
  end

  typedef enum logic [2:0] {
    ST_CLEAR,
    ST_WAIT_INIT,
    ST_LOAD,
    ST_DONE,
    ST_FAIL
  } sfc_state_e;

  logic               rst_s1_r, rst_n_r;
  sfc_pkg::sfc_pins_s pin_raw, pin_s1_r, pin_s_r, boot_r;
  sfc_pkg::sfc_rd_s   rd_r, rd_dec;
  sfc_state_e         st_r;
  logic               init_q_r, init_rise, boot_ok, prog_hit;
  logic [15:0]        clr_cnt_r;
  logic [7:0]         prog_cnt_r;
  logic               go_r, fast_r;
  logic               tgl_s1_r, tgl_s2_r, tgl_s3_r, byte_tgl;
  logic [7:0]         link_byte;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  assign pin_raw = {reprogram_n_i, init_i, done_i, pullup_disable_pin_i,
                    mode_pins_i, flash_variant_pins_i};

  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_s1_r <= '0;
      pin_s_r <= '0;
      init_q_r <= 1'b0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s_r <= pin_s1_r;
      init_q_r <= pin_s_r.init;
    end
  end

  assign init_rise = pin_s_r.init && !init_q_r;
  assign rd_dec    = sfc_pkg::sfc_decode(pin_s_r.variant);
  assign boot_ok   = pin_s_r.mode == sfc_pkg::MODE_SPI && rd_dec.ok;
  assign prog_hit  = prog_cnt_r == PROG_CYC;

  // ---------------------------------------------------------------
  // Reprogram pulse width
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prog_cnt_r <= 8'h00;
    end else if (pin_s_r.reprog_n) begin
      prog_cnt_r <= 8'h00;
    end else if (!prog_hit) begin
      prog_cnt_r <= prog_cnt_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Memory clear timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      clr_cnt_r <= 16'h0000;
    end else if (st_r != ST_CLEAR || !pin_s_r.reprog_n) begin
      clr_cnt_r <= 16'h0000;
    end else if (clr_cnt_r != CLEAR_M1) begin
      clr_cnt_r <= clr_cnt_r + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r <= ST_CLEAR;
    end else if (prog_hit) begin
      st_r <= ST_CLEAR;
    end else begin
      unique case (st_r)
        ST_CLEAR: begin
          if (pin_s_r.reprog_n && clr_cnt_r == CLEAR_M1) begin
            st_r <= ST_WAIT_INIT;
          end
        end
        ST_WAIT_INIT: begin
          if (init_rise) begin
            st_r <= boot_ok ? ST_LOAD : ST_FAIL;
          end
        end
        ST_LOAD: begin
          if (load_complete_i) begin
            st_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          st_r <= ST_DONE;
        end
        ST_FAIL: begin
          st_r <= ST_FAIL;
        end
      endcase
    end
  end

  // Boot pins and read protocol are caught once, on the init rise.
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      boot_r <= '0;
      rd_r <= '0;
    end else if (st_r == ST_WAIT_INIT && init_rise) begin
      boot_r <= pin_s_r;
      rd_r <= rd_dec;
    end
  end

  // ---------------------------------------------------------------
  // Link control
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      go_r <= 1'b0;
      fast_r <= 1'b0;
    end else begin
      go_r <= st_r == ST_LOAD && !load_complete_i && !prog_hit;
      fast_r <= st_r == ST_LOAD && (fast_r || fast_rate_i);
    end
  end

  // Only select, clock, data out and data in reach the flash.
  sfc_spi_reader #(
    .SLOW_DIV   (SLOW_DIV),
    .FAST_DIV   (FAST_DIV),
    .START_ADDR (START_ADDR)
  ) u_reader (
    .osc_clk_i  (osc_clk_i),
    .arst_n_i   (arst_n_i),
    .go_i       (go_r),
    .fast_i     (fast_r),
    .rd_i       (rd_r),
    .cs_n_o     (flash_select_n_o),
    .sclk_o     (config_clock_o),
    .mosi_o     (mosi_o),
    .din_i      (din_i),
    .byte_o     (link_byte),
    .byte_tgl_o (byte_tgl)
  );

  // ---------------------------------------------------------------
  // Received bytes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      {tgl_s1_r, tgl_s2_r, tgl_s3_r} <= 3'h0;
      data_o <= 8'h00;
      data_valid_o <= 1'b0;
    end else begin
      tgl_s1_r <= byte_tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
      data_valid_o <= (tgl_s2_r ^ tgl_s3_r) && st_r == ST_LOAD;
      if (tgl_s2_r ^ tgl_s3_r) begin
        data_o <= link_byte;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers and status
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      init_o <= 1'b0;
      init_oe_o <= 1'b1;
      done_o <= 1'b0;
      done_oe_o <= 1'b1;
    end else begin
      init_o <= 1'b0;
      init_oe_o <= st_r == ST_CLEAR || st_r == ST_FAIL;
      done_o <= 1'b0;
      done_oe_o <= st_r != ST_DONE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      chain_out_o <= 1'b0;
      chain_out_oe_o <= 1'b1;
    end else begin
      chain_out_o <= 1'b1;
      chain_out_oe_o <= st_r != ST_DONE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pullup_en_o <= 1'b0;
      pins_released_o <= 1'b0;
      configuring_o <= 1'b1;
      mode_error_o <= 1'b0;
    end else begin
      pullup_en_o <= st_r != ST_DONE && !pin_s_r.pullup_dis;
      pins_released_o <= st_r == ST_DONE && pin_s_r.done;
      configuring_o <= st_r != ST_DONE;
      mode_error_o <= st_r == ST_FAIL;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_r);

  sequence s_boot_ok;
    st_r == ST_WAIT_INIT && init_rise && boot_ok && !prog_hit;
  endsequence

  sequence s_boot_bad;
    st_r == ST_WAIT_INIT && init_rise && !boot_ok && !prog_hit;
  endsequence

  a_boot_start: assert property (s_boot_ok |=> st_r == ST_LOAD ##1 go_r)
    else $error("valid boot pins did not start the load");
  a_boot_reject: assert property (s_boot_bad |=> st_r == ST_FAIL ##1 mode_error_o)
    else $error("bad boot pins did not fail");
  a_boot_latch: assert property (s_boot_ok |=> boot_r == $past(pin_s_r))
    else $error("boot pins not latched on init rise");
  a_variant_cmd: assert property (st_r == ST_LOAD |-> rd_r == sfc_pkg::sfc_decode(boot_r.variant))
    else $error("read protocol does not match latched variant");
  a_pins_release: assert property ((st_r == ST_DONE && pin_s_r.done) |=> pins_released_o)
    else $error("pins not released after done");
  a_pins_hold: assert property (st_r != ST_DONE |=> !pins_released_o)
    else $error("pins released before done");
  a_pullup_ctrl: assert property (st_r != ST_DONE |=> pullup_en_o == !$past(pin_s_r.pullup_dis))
    else $error("pull-up enable does not follow control pin");
  a_chain_drive: assert property (($past(rst_n_r) && $past(st_r) != ST_DONE) |-> chain_out_oe_o && chain_out_o)
    else $error("chain output not driven during configuration");
  a_init_clear: assert property ((st_r == ST_CLEAR) |=> init_oe_o)
    else $error("init indicator not held low during memory clear");
  a_init_release: assert property ((st_r == ST_WAIT_INIT) |=> !init_oe_o)
    else $error("init indicator not released after memory clear");

endmodule // sfc_config_loader

// ==== sfc_flash_model.sv ====
// Behavioural serial flash that serves the configuration bitstream.
`timescale 1ns/1ps
module sfc_flash_model (
  // Flash pins
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  input  wire logic        mosi_i,
  output logic             dout_o,
  // Board ties that must stay high for a read to be served
  input  wire logic        hold_n_i,
  input  wire logic        reset_n_i,
  // Captured header
  output logic [7:0]       cmd_o,
  output logic [23:0]      addr_o
);
  // ---------------------------------------------------------------
  // Serial protocol
  // ---------------------------------------------------------------
  int          nbit = 0;
  int          hdr  = 32;
  int          k;
  logic [31:0] sh   = '0;
  logic [7:0]  bval;
  initial dout_o = 1'b0;
  // Low hold or low reset pauses the read.
  // Header bits are taken on the rising clock.
  always @(posedge sclk_i) begin
    if (!cs_n_i && hold_n_i && reset_n_i) begin
      if (nbit < 32) sh = {sh[30:0], mosi_i};
      if (nbit == 7) hdr = 32 + 8 * ((sh[7:0] == 8'h0b) ? 1 : (sh[7:0] == 8'he8) ? 3 : 0);
      if (nbit == 31) begin
        cmd_o  = sh[31:24];
        addr_o = sh[23:0];
      end
      nbit++;
    end
  end
  // Data changes on the falling clock; byte n holds 3c plus n.
  always @(negedge sclk_i) begin
    if (!cs_n_i && hold_n_i && reset_n_i) begin
      if (nbit >= hdr) begin
        k      = nbit - hdr;
        bval   = 8'h3c + 8'(k / 8);
        dout_o = bval[7 - k % 8];
      end else begin
        dout_o = ~dout_o;
      end
    end
  end
  // A deselected flash floats its output, shown as an inverted level.
  always @(posedge cs_n_i) begin
    nbit   = 0;
    hdr    = 32;
    dout_o = ~dout_o;
  end
endmodule // sfc_flash_model

// ==== tb_sfc_config_loader.sv ====
// Testbench of the serial-flash configuration loader.
`timescale 1ns/1ps
module tb_sfc_config_loader;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  localparam logic [2:0] VARS [3] = '{sfc_pkg::VAR_FAST, sfc_pkg::VAR_READ, sfc_pkg::VAR_ARRAY};
  localparam logic [7:0] CMDS [3] = '{sfc_pkg::CMD_FAST, sfc_pkg::CMD_READ, sfc_pkg::CMD_ARRAY};
  logic        clk_i = 1'b0;
  logic        osc_clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        reprogram_n_i = 1'b1;
  logic [2:0]  mode_pins_i = sfc_pkg::MODE_SPI;
  logic [2:0]  var_pins = sfc_pkg::VAR_FAST;
  logic        pud = 1'b0;
  logic        load_cpl = 1'b0;
  logic        fast = 1'b0;
  logic        init_o, init_oe_o, done_o, done_oe_o, cs_n, sclk, mosi, din;
  logic        chain_o, chain_oe, dv, pu_en, rel, cfg, merr;
  logic [7:0]  data;
  logic [7:0]  f_cmd;
  logic [23:0] f_addr;
  int          n_fail = 0;
  int          checks = 0;
  wire         init_w = init_oe_o ? init_o : 1'b1;
  wire         done_w = done_oe_o ? done_o : 1'b1;
  always #5 clk_i = ~clk_i;
  always #16 osc_clk_i = ~osc_clk_i;
  sfc_config_loader #(.CLEAR_CYC(4), .SLOW_DIV(8), .FAST_DIV(3)) i_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .osc_clk_i(osc_clk_i), .reprogram_n_i(reprogram_n_i),
    .mode_pins_i(mode_pins_i), .flash_variant_pins_i(var_pins), .pullup_disable_pin_i(pud),
    .init_i(init_w), .init_o(init_o), .init_oe_o(init_oe_o), .done_i(done_w), .done_o(done_o),
    .done_oe_o(done_oe_o), .flash_select_n_o(cs_n), .config_clock_o(sclk), .mosi_o(mosi),
    .din_i(din), .chain_out_o(chain_o), .chain_out_oe_o(chain_oe), .load_complete_i(load_cpl),
    .fast_rate_i(fast), .data_o(data), .data_valid_o(dv), .pullup_en_o(pu_en),
    .pins_released_o(rel), .configuring_o(cfg), .mode_error_o(merr));
  sfc_flash_model i_flash (.cs_n_i(cs_n), .sclk_i(sclk), .mosi_i(mosi), .dout_o(din),
    .hold_n_i(1'b1), .reset_n_i(1'b1), .cmd_o(f_cmd), .addr_o(f_addr));
  // ---------------------------------------------------------------
  // Tasks and scenarios
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return cs_n;
      1: return dv;
      2: return cfg;
      3: return merr;
      5: return rel;
      default: return init_w;
    endcase
  endfunction
  task automatic wait_until(input int k, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && sig(k) !== v; i++) @(negedge clk_i);
    if (i == lim) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, sig(k), v);
      end_sim();
    end
  endtask
  task automatic do_reset();
    arst_n_i = 1'b0;
    repeat (16) @(negedge clk_i);
    arst_n_i = 1'b1;
  endtask
  task automatic t_load(input int v, input logic pu, input logic fr);
    time t0;
    mode_pins_i = sfc_pkg::MODE_SPI;
    var_pins = VARS[v];
    pud = pu;
    fast = fr;
    do_reset();
    chk(init_oe_o, 1'b1);
    wait_until(4, 1'b1, 200);
    wait_until(0, 1'b0, 100);
    mode_pins_i = 3'h6;
    var_pins = ~VARS[v];
    chk(pu_en, !pu);
    chk({chain_oe, chain_o}, 2'h3);
    for (int k = 0; k < 3; k++) begin
      wait_until(1, 1'b1, 20000);
      chk(data, 8'h3c + 8'(k));
      if (k == 2) chk(($time - t0) < 3000, fr);
      t0 = $time;
      @(negedge clk_i);
    end
    chk({f_cmd, f_addr}, {CMDS[v], sfc_pkg::START_ADDR_DEF});
    load_cpl = 1'b1;
    wait_until(2, 1'b0, 20);
    load_cpl = 1'b0;
    wait_until(5, 1'b1, 20);
    chk({done_oe_o, chain_oe, merr}, 3'h0);
    wait_until(0, 1'b1, 50);
  endtask
  task automatic t_bad(input logic [2:0] m, input logic [2:0] v);
    mode_pins_i = m;
    var_pins = v;
    do_reset();
    wait_until(3, 1'b1, 300);
    chk({cs_n, init_oe_o}, 2'h3);
  endtask
  task automatic t_reprog();
    mode_pins_i = sfc_pkg::MODE_SPI;
    var_pins = sfc_pkg::VAR_READ;
    do_reset();
    wait_until(0, 1'b0, 300);
    reprogram_n_i = 1'b0;
    repeat (60) @(negedge clk_i);
    chk({cs_n, init_oe_o}, 2'h3);
    reprogram_n_i = 1'b1;
    wait_until(0, 1'b0, 300);
    wait_until(1, 1'b1, 20000);
    chk({data, f_cmd}, {8'h3c, sfc_pkg::CMD_READ});
  endtask
  initial begin
    t_load(0, 1'b0, 1'b0);
    t_load(1, 1'b1, 1'b1);
    t_load(2, 1'b0, 1'b1);
    for (int m = 0; m < 8; m++) begin
      if (m != 1) t_bad(3'(m), sfc_pkg::VAR_FAST);
    end
    t_bad(sfc_pkg::MODE_SPI, 3'h0);
    t_reprog();
    end_sim();
  end
endmodule // tb_sfc_config_loader
